// >>> logic/emb_pkg.sv
// Constants and carrier types for the external memory bus control block.
// Assumes a single oscillator-rate clock; one clock edge is one osc period.
package emb_pkg;

  // ****************************************************************
  // Bus timing, in oscillator periods
  // ****************************************************************
  localparam logic [3:0]  EMB_CYCLE_LAST   = 4'hB;   // 12 periods per cycle
  localparam logic [3:0]  EMB_SLOT_LEN     = 4'h6;   // One strobe every six
  localparam logic [2:0]  EMB_SLOT_LAST    = 3'h5;   // Last period of a slot
  localparam logic [2:0]  EMB_ALE_LEN      = 3'h2;   // Latch strobe width
  localparam logic [2:0]  EMB_ADDR_HOLD    = 3'h3;   // Low address held
  localparam logic [2:0]  EMB_PSTB_FIRST   = 3'h2;   // Program strobe start
  localparam logic [3:0]  EMB_DSTB_FIRST   = 4'h3;   // Data strobe start
  localparam logic [3:0]  EMB_DSTB_LAST    = 4'hA;   // Data strobe end

  // ****************************************************************
  // Program space split and reset values
  // ****************************************************************
  localparam logic [15:0] EMB_INT_ROM_LIMIT = 16'h2000; // 8192 bytes
  localparam logic [7:0]  EMB_PORT_ONES     = 8'hFF;
  localparam logic [7:0]  EMB_PORT_ZERO     = 8'h00;

  // Kind of the current machine cycle
  typedef enum logic {
    EMB_CYC_FETCH,
    EMB_CYC_DATA
  } emb_cyc_e;

  // External data move request from the core
  typedef struct packed {
    logic        wide;    // 16-bit pointer form
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } emb_dreq_s;

  // One 8-bit port pin group: drive value, strong enable, weak pull-up
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] weak_pu;
  } emb_port_s;

endpackage

// >>> logic/emb_ctrl.sv
// External program and data memory bus control.
// Assumes clk_i is the oscillator input rate and that the core holds a
// data request valid until it sees the acknowledge.
//
// Operation
// - The internal clock is the oscillator clock halved by a toggle.
// - A high port pin whose latch holds one is only pulled up weakly.
// - The high port drives the upper address on external fetches and wide-pointer moves.
// - Address ones on the high port are driven strongly.
// - Narrow-pointer moves leave the port latch contents on the high port.
// - The program strobe pulses every six periods on external fetch, never in data cycles.
// - The program strobe stays high while fetching internally.
// - The latch strobe pulses every six periods except in the second half of data cycles.
// - With the select high, addresses below 8192 are fetched internally.
// - With the select low, every fetch is external.
// - The low port carries address then data during external accesses.
module emb_ctrl
  import emb_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      srst_i,
  // Core side: fetch
  input  wire logic [15:0] program_counter_i,
  output logic           fetch_external_o,
  output logic           fetch_valid_o,
  output logic [7:0]     fetch_data_o,
  // Core side: data moves and port latch
  input  wire logic      data_req_valid_i,
  input  wire emb_dreq_s data_req_i,
  output logic           data_req_ack_o,
  output logic           data_done_o,
  output logic [7:0]     data_rdata_o,
  input  wire logic [7:0] high_port_latch_i,
  output logic [7:0]     high_port_rd_o,
  output logic           int_clk_o,
  // Pins
  input  wire logic      ext_fetch_select_i,
  input  wire logic [7:0] low_addr_data_port_i,
  output emb_port_s      low_addr_data_port_o,
  input  wire logic [7:0] high_addr_port_i,
  output emb_port_s      high_addr_port_o,
  output logic           ale_o,
  output logic           program_read_strobe_n_o,
  output logic           data_read_strobe_n_o,
  output logic           data_write_strobe_n_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Position inside the current six-period slot
  function automatic logic [2:0] emb_slot_pos(input logic [3:0] cnt);
    logic [3:0] p;
    p = (cnt >= EMB_SLOT_LEN) ? cnt - EMB_SLOT_LEN : cnt;
    return p[2:0];
  endfunction

  // Fetch from outside when the select is low or the address is high
  function automatic logic emb_fetch_ext(input logic sel,
                                         input logic [15:0] pc);
    return !sel || (pc >= EMB_INT_ROM_LIMIT);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [3:0]  cnt_q;
  emb_cyc_e    kind_q;
  logic        slot_ext_q;
  logic [15:0] slot_pc_q;
  emb_dreq_s   dreq_q;
  logic        sel_s1, sel_s2;
  logic        fetch_smp_q;
  logic [7:0]  lo_s1, lo_s2;
  logic [7:0]  hi_s1, hi_s2;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire logic [2:0]  pos        = emb_slot_pos(cnt_q);
  wire logic        cyc_end    = (cnt_q == EMB_CYCLE_LAST);
  wire logic        slot_end   = (pos == EMB_SLOT_LAST);
  wire logic        in_data    = (kind_q == EMB_CYC_DATA);
  wire logic        data_late  = in_data && (cnt_q >= EMB_SLOT_LEN);
  wire logic        fetch_ext  = !in_data && slot_ext_q;
  wire logic        next_ext   = emb_fetch_ext(sel_s2, program_counter_i);
  wire logic        in_dstb    = in_data && (cnt_q >= EMB_DSTB_FIRST)
                                 && (cnt_q <= EMB_DSTB_LAST);
  wire logic        ale_w      = (pos < EMB_ALE_LEN) && !data_late;
  wire logic        pstb_w     = fetch_ext && (pos >= EMB_PSTB_FIRST);
  wire logic        lo_addr_w  = (pos < EMB_ADDR_HOLD)
                                 && (fetch_ext || (in_data && !data_late));
  wire logic        lo_wr_w    = in_data && dreq_q.write
                                 && (cnt_q >= EMB_DSTB_FIRST);
  wire logic        hi_addr_w  = fetch_ext || (in_data && dreq_q.wide);
  wire logic [15:0] addr_w     = in_data ? dreq_q.addr : slot_pc_q;
  wire emb_cyc_e    next_kind  = (cyc_end && data_req_valid_i) ?
                                 EMB_CYC_DATA : EMB_CYC_FETCH;
  wire emb_port_s   next_lo;
  wire emb_port_s   next_hi;

  // Request taken only at a cycle boundary so a fetch slot never splits
  assign data_req_ack_o = cyc_end && data_req_valid_i;

  // Low port: address, then write data, else floating for reads
  assign next_lo.dout    = lo_addr_w ? addr_w[7:0] : dreq_q.wdata;
  assign next_lo.oe      = (lo_addr_w || lo_wr_w) ? EMB_PORT_ONES
                                                  : EMB_PORT_ZERO;
  assign next_lo.weak_pu = EMB_PORT_ZERO;

  // High port: strong address drive, otherwise plain latch behaviour
  assign next_hi.dout    = hi_addr_w ? addr_w[15:8]
                                     : high_port_latch_i;
  assign next_hi.oe      = hi_addr_w ? EMB_PORT_ONES
                                     : ~high_port_latch_i;
  assign next_hi.weak_pu = hi_addr_w ? EMB_PORT_ZERO
                                     : high_port_latch_i;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Two stages on every pin input before any logic looks at it
  always_ff @(posedge clk_i) begin
    sel_s1 <= ext_fetch_select_i;
    sel_s2 <= sel_s1;
    lo_s1 <= low_addr_data_port_i;
    lo_s2 <= lo_s1;
    hi_s1 <= high_addr_port_i;
    hi_s2 <= hi_s1;
  end

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  // Toggle halves the oscillator; no duty cycle demand on the input
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      int_clk_o <= 1'b0;
    end else begin
      int_clk_o <= ~int_clk_o;
    end
  end

  // Period counter, cycle kind and per-slot fetch source
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q      <= 4'h0;
      kind_q     <= EMB_CYC_FETCH;
      slot_ext_q <= 1'b0;
      slot_pc_q  <= 16'h0000;
      dreq_q     <= '0;
    end else begin
      cnt_q <= cyc_end ? 4'h0 : cnt_q + 4'h1;
      if (cyc_end) begin
        kind_q <= next_kind;
        dreq_q <= data_req_i;
      end
      if (slot_end) begin
        slot_ext_q <= next_ext;
        slot_pc_q  <= program_counter_i;
      end
    end
  end

  // Registered pins; reads sample the synchronised port, which lags the
  // pin by two periods, so memory must answer early in the strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ale_o                   <= 1'b0;
      program_read_strobe_n_o <= 1'b1;
      data_read_strobe_n_o    <= 1'b1;
      data_write_strobe_n_o   <= 1'b1;
      low_addr_data_port_o    <= '0;
      high_addr_port_o        <= '{dout: EMB_PORT_ONES, oe: EMB_PORT_ZERO,
                                   weak_pu: EMB_PORT_ONES};
    end else begin
      ale_o                   <= ale_w;
      program_read_strobe_n_o <= !pstb_w;
      data_read_strobe_n_o    <= !(in_dstb && !dreq_q.write);
      data_write_strobe_n_o   <= !(in_dstb && dreq_q.write);
      low_addr_data_port_o    <= next_lo;
      high_addr_port_o        <= next_hi;
    end
  end

  // Results back to the core
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fetch_smp_q      <= 1'b0;
      fetch_valid_o    <= 1'b0;
      fetch_data_o     <= 8'h00;
      data_done_o      <= 1'b0;
      data_rdata_o     <= 8'h00;
      fetch_external_o <= 1'b0;
      high_port_rd_o   <= 8'h00;
    end else begin
      fetch_smp_q      <= fetch_ext && slot_end;
      fetch_valid_o    <= fetch_smp_q;
      data_done_o      <= in_data && (cnt_q == EMB_DSTB_LAST);
      fetch_external_o <= fetch_ext;
      high_port_rd_o   <= hi_s2;
      // One period after slot end: before that the synchronised port
      // still shows the address that stood before the port was released
      if (fetch_smp_q) begin
        fetch_data_o <= lo_s2;
      end
      if (in_data && !dreq_q.write && (cnt_q == EMB_DSTB_LAST)) begin
        data_rdata_o <= lo_s2;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Reset stretched by one period for the checks, so that no attempt
  // starts on the release edge while outputs still hold reset values
  logic        rst_q;
  always_ff @(posedge clk_i) begin
    rst_q <= srst_i;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i || rst_q);

  sequence s_pstb_low;
    !program_read_strobe_n_o [*4];
  endsequence

  sequence s_ale_pulse;
    ale_o [*2] ##1 !ale_o [*4];
  endsequence

  a_clk_halves: assert property (
    ##1 (int_clk_o != $past(int_clk_o)))
    else $error("internal clock did not toggle");

  a_port_weak_one: assert property (
    !hi_addr_w |=> (high_addr_port_o.oe == ~$past(high_port_latch_i))
      && (high_addr_port_o.weak_pu == $past(high_port_latch_i))
      && (high_addr_port_o.dout == $past(high_port_latch_i)))
    else $error("high port latch drive wrong");

  a_addr_high_out: assert property (
    hi_addr_w |=> (high_addr_port_o.dout == $past(addr_w[15:8]))
      && (high_addr_port_o.oe == EMB_PORT_ONES)
      && (high_addr_port_o.weak_pu == EMB_PORT_ZERO))
    else $error("high address not driven strongly");

  a_pstb_width: assert property (
    $fell(program_read_strobe_n_o) |-> s_pstb_low ##1 program_read_strobe_n_o)
    else $error("program strobe width wrong");

  a_pstb_data_idle: assert property (
    in_data |=> program_read_strobe_n_o && !(data_late && ale_o))
    else $error("strobe during data cycle");

  a_pstb_internal: assert property (
    (!in_data && !slot_ext_q) |=> program_read_strobe_n_o)
    else $error("program strobe on internal fetch");

  a_ale_every_six: assert property (
    (pos == 3'h0 && !data_late) |=> s_ale_pulse)
    else $error("latch strobe pattern wrong");

  a_ale_skip_data: assert property (
    (in_data && cnt_q == 4'h6) |=> !ale_o [*6])
    else $error("latch strobe in data cycle second half");

  a_fetch_internal: assert property (
    (slot_end && sel_s2 && program_counter_i < EMB_INT_ROM_LIMIT)
      |=> !slot_ext_q)
    else $error("low address fetched externally");

  a_fetch_all_ext: assert property (
    (slot_end && !sel_s2) |=> slot_ext_q)
    else $error("fetch not external with select low");

  a_low_port_mux: assert property (
    lo_addr_w |=> (low_addr_data_port_o.dout == $past(addr_w[7:0]))
      && (low_addr_data_port_o.oe == EMB_PORT_ONES))
    else $error("low address not on low port");

endmodule

// >>> sim/emb_mem_model.sv
// External memory and address latch model for the bus control bench.
// Assumes block pin outputs change only just after clk_i edges.
module emb_mem_model
  import emb_pkg::*;
(
  // Clock
  input  wire logic      clk_i,
  // Strobes and ports from the block
  input  wire logic      ale_i,
  input  wire logic      pstb_n_i,
  input  wire logic      rd_n_i,
  input  wire emb_port_s lo_port_i,
  input  wire emb_port_s hi_port_i,
  // Resolved pin levels
  output logic [7:0]     lo_pin_o,
  output logic [7:0]     hi_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] addr;
  logic        ale_d = 1'b0;
  logic [7:0]  flt   = 8'h00;
  logic [7:0]  mem_q;

  // Every address holds a byte made from its own address bits
  assign mem_q = addr[7:0] ^ addr[15:8] ^ 8'h5A;
  // Low port has no pull-up, so a released bit keeps changing
  assign lo_pin_o = (lo_port_i.oe & lo_port_i.dout) |
    (~lo_port_i.oe & ((!pstb_n_i || !rd_n_i) ? mem_q : flt));
  // High port bits without drive read one where weakly pulled up, else keep changing
  assign hi_pin_o = (hi_port_i.oe & hi_port_i.dout) |
    (~hi_port_i.oe & (hi_port_i.weak_pu | flt));

  // Capture the address as the latch strobe falls
  always @(posedge clk_i) begin
    flt   <= ~lo_pin_o;
    ale_d <= ale_i;
    if (ale_d && !ale_i) begin
      addr <= {hi_pin_o, lo_pin_o};
    end
  end
endmodule

// >>> sim/external_memory_bus_control_test.sv
// Self-checking bench for the external memory bus control block.
// Assumes the memory model resolves both address ports.
module external_memory_bus_control_test
  import emb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_i = 1'b0;
  logic        srst_i, data_req_valid_i, ext_fetch_select_i;
  logic        fetch_external_o, fetch_valid_o, data_req_ack_o;
  logic        data_done_o, int_clk_o, ale_o, program_read_strobe_n_o;
  logic        data_read_strobe_n_o, data_write_strobe_n_o;
  logic [7:0]  high_port_rd_o;
  logic [15:0] program_counter_i;
  logic [7:0]  fetch_data_o, data_rdata_o, high_port_latch_i, lo_pin, hi_pin;
  emb_dreq_s   data_req_i;
  emb_port_s   low_addr_data_port_o, high_addr_port_o;
  int          failures = 0;
  int          cmp_count = 0;

  emb_ctrl emb_ctrl_inst (
    .clk_i(clk_i), .srst_i(srst_i), .program_counter_i(program_counter_i),
    .fetch_external_o(fetch_external_o), .fetch_valid_o(fetch_valid_o),
    .fetch_data_o(fetch_data_o), .data_req_valid_i(data_req_valid_i),
    .data_req_i(data_req_i), .data_req_ack_o(data_req_ack_o),
    .data_done_o(data_done_o), .data_rdata_o(data_rdata_o),
    .high_port_latch_i(high_port_latch_i), .high_port_rd_o(high_port_rd_o),
    .int_clk_o(int_clk_o), .ext_fetch_select_i(ext_fetch_select_i),
    .low_addr_data_port_i(lo_pin), .low_addr_data_port_o(low_addr_data_port_o),
    .high_addr_port_i(hi_pin), .high_addr_port_o(high_addr_port_o),
    .ale_o(ale_o), .program_read_strobe_n_o(program_read_strobe_n_o),
    .data_read_strobe_n_o(data_read_strobe_n_o),
    .data_write_strobe_n_o(data_write_strobe_n_o));

  emb_mem_model emb_mem_model_inst (
    .clk_i(clk_i), .ale_i(ale_o), .pstb_n_i(program_read_strobe_n_o),
    .rd_n_i(data_read_strobe_n_o), .lo_port_i(low_addr_data_port_o),
    .hi_port_i(high_addr_port_o), .lo_pin_o(lo_pin), .hi_pin_o(hi_pin));

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish;
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Fixed fetch source; counts are phase free over two machine cycles
  task automatic fetch_case(input logic sel, input logic [15:0] pc,
                            input int exp_pl);
    int pl, ah;
    @(posedge clk_i);
    ext_fetch_select_i <= sel;
    program_counter_i  <= pc;
    repeat (24) @(posedge clk_i);
    pl = 0;
    ah = 0;
    repeat (24) begin
      @(posedge clk_i);
      #1;
      pl += (program_read_strobe_n_o === 1'b0);
      ah += (ale_o === 1'b1);
    end
    check(pl, exp_pl, "program strobe count");
    check(ah, 8, "latch strobe count");
    check(fetch_external_o, exp_pl != 0, "fetch source");
    if (exp_pl != 0) begin
      check(high_addr_port_o.dout, pc[15:8], "high address");
      check(high_addr_port_o.oe, 8'hFF, "strong drive");
      for (int i = 0; i < 12 && fetch_valid_o !== 1'b1; i++) begin
        @(posedge clk_i);
        #1;
      end
      check(fetch_data_o, mem_byte(pc), "fetched byte");
    end
  endtask

  // One data move, then the fetch cycle that follows it
  task automatic move_case(input logic wide, input logic wr,
                           input logic [15:0] a);
    int          pl, ah;
    logic        seen;
    logic [7:0]  rd;
    logic [15:0] eff_a;
    eff_a = wide ? a : {high_port_latch_i, a[7:0]};
    seen = 1'b0;
    rd = 8'h00;
    pl = 0;
    ah = 0;
    @(posedge clk_i);
    data_req_i       <= '{wide: wide, write: wr, addr: a, wdata: 8'hA5};
    data_req_valid_i <= 1'b1;
    for (int i = 0; i < 14 && data_req_ack_o !== 1'b1; i++) @(posedge clk_i);
    data_req_valid_i <= 1'b0;
    for (int k = 1; k <= 24; k++) begin
      @(posedge clk_i);
      #1;
      pl += (program_read_strobe_n_o === 1'b0);
      ah += (ale_o === 1'b1);
      if (data_done_o === 1'b1) begin
        seen = 1'b1;
        rd = data_rdata_o;
      end
      if (k == 6) begin
        check(data_read_strobe_n_o, wr, "read strobe");
        check(data_write_strobe_n_o, !wr, "write strobe");
        check(low_addr_data_port_o.oe, {8{wr}}, "low drive");
      end
      if (k == 6 && wr) begin
        check(low_addr_data_port_o.dout, 8'hA5, "write data");
      end
      if (k == 6 && wide) begin
        check(high_addr_port_o.dout, a[15:8], "wide pointer");
        check(high_addr_port_o.oe, 8'hFF, "wide drive");
      end
      if (k == 6 && !wide) begin
        check(high_addr_port_o.weak_pu, high_port_latch_i, "latch");
        check(high_addr_port_o.oe & high_port_latch_i, 0, "weak");
        check(high_port_rd_o, high_port_latch_i, "pin read");
      end
    end
    check(pl, 8, "strobe skipped in data cycle");
    check(ah, 6, "latch strobe skipped");
    check(seen, 1'b1, "data cycle done");
    if (!wr) begin
      check(rd, mem_byte(eff_a), "read byte");
    end
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    logic t;
    srst_i = 1'b1;
    data_req_valid_i = 1'b0;
    data_req_i = '0;
    ext_fetch_select_i = 1'b0;
    program_counter_i = 16'h0000;
    high_port_latch_i = 8'hC3;
    repeat (4) @(posedge clk_i);
    #1;
    check(high_addr_port_o.weak_pu, 8'hFF, "reset pull-up");
    check(program_read_strobe_n_o, 1'b1, "reset strobe");
    @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    t = int_clk_o;
    @(posedge clk_i);
    #1;
    check(int_clk_o, !t, "halved clock");
    fetch_case(1'b0, 16'hFF23, 16);
    fetch_case(1'b1, 16'h1FFF, 0);
    fetch_case(1'b1, 16'h2000, 16);
    move_case(1'b1, 1'b0, 16'h34A7);
    move_case(1'b0, 1'b0, 16'h0066);
    move_case(1'b1, 1'b1, 16'h5A10);
    tally_and_finish;
  end

  // Whole run takes under 300 cycles; cut a hang well beyond that
  initial begin
    repeat (2000) @(posedge clk_i);
    failures++;
    tally_and_finish;
  end
endmodule
